//--- cpwm_defs.vh
// Constants for the counter and pulse-output parameter and diagnostic map
`ifndef CPWM_DEFS_VH
`define CPWM_DEFS_VH
`define EMCY_CODE_GENERAL 16'h7010
`define EMCY_CODE_DIAG_CHG 16'h7011
`define EMCY_ERR_GENERAL 8'h81
`define EMCY_BASE_ID 11'h081
`define EMCY_ID_OFFSET 11'h001
`define ERRREG_GENERIC_BIT 0
`define ERRREG_MANUF_BIT 7
`define DIAG_HW_BIT 7
`define DIAG_PAR_BIT 6
`define DIAG_PULSE_BIT 1
`define DIAG_AUX_BIT 0
`define DIR_BASIC 2'h0
`define DIR_NONE 2'h1
`define DIR_UP 2'h2
`define DIR_DOWN 2'h3
`define FILT_2US 2'h0
`define FILT_16US 2'h1
// Filter lengths counted in 50 ns clock cycles
`define FILT_2US_CYC 10'h028
`define FILT_16US_CYC 10'h140
`define IDX_PLAIN 4'hf
`define CNT_MODE_QUAD4 4'h4
`define CNT_MODE_PLAIN 4'hf
`define STS_WINDOW 2'h0
`define STS_PULSE 2'h3
`define PWM_PERIOD_DUTY_DEFINITION 4'h0
`define PWM_HIGH_LOW_TIME_DEFINITION 4'h1
`define PWM_PLAIN 4'hf
`define AUX_MODE_RST 6'h3f
`define AUX_RD1_RST 8'h20
`define AUX_RD2_RST 8'h21
`define AUX_RD3_RST 8'h40
`define AUX_WR1_RST 8'h60
`define AUX_WR2_RST 8'h61
`define AUX_WR3_RST 8'h70
`define REV_MULT 16'h03e8
`endif

//--- cpwm_input_cond.v
// Track input conditioner: polarity select and digital filter
`default_nettype none
`include "cpwm_defs.vh"
module cpwm_input_cond (
	input wire clk_i,
	input wire rst_i,
	input wire raw_i,
	input wire invert_i,
	input wire [1:0] filter_i,
	output reg clean_o
);
	wire lvl;
	wire [9:0] need;
	reg [9:0] stable_r;
	// Inverter sits ahead of the filter so both polarities filter the same
	assign lvl = invert_i ? ~raw_i : raw_i;
	// Reserved filter codes fall back to the short filter
	assign need = (filter_i == `FILT_16US) ? `FILT_16US_CYC : `FILT_2US_CYC;
	// Output follows only after the level held for the whole filter time
	always @(posedge clk_i) begin
		if (rst_i) begin
			stable_r <= 10'h000;
			clean_o <= 1'b0;
		end else if (lvl == clean_o) begin
			stable_r <= 10'h000;
		end else if (stable_r >= need - 10'h001) begin
			stable_r <= 10'h000;
			clean_o <= lvl;
		end else begin
			stable_r <= stable_r + 10'h001;
		end
	end
endmodule
`default_nettype wire

//--- cpwm_diag_byte.v
// One diagnostic byte with mask and change detection
`default_nettype none
`include "cpwm_defs.vh"
module cpwm_diag_byte (
	input wire clk_i,
	input wire rst_i,
	input wire mask_i,
	input wire hw_fault_i,
	input wire par_fault_i,
	input wire pulse_diag_i,
	input wire aux_diag_i,
	output reg [7:0] diag_o,
	output wire changed_o
);
	reg [7:0] raw;
	// Masked unit reports nothing at all
	always @* begin
		raw = 8'h00;
		raw[`DIAG_HW_BIT] = hw_fault_i;
		raw[`DIAG_PAR_BIT] = par_fault_i;
		raw[`DIAG_PULSE_BIT] = pulse_diag_i;
		raw[`DIAG_AUX_BIT] = aux_diag_i;
		if (mask_i) begin
			raw = 8'h00;
		end
	end
	assign changed_o = (raw != diag_o);
	always @(posedge clk_i) begin
		if (rst_i) begin
			diag_o <= 8'h00;
		end else begin
			diag_o <= raw;
		end
	end
endmodule
`default_nettype wire

//--- cpwm_param_diag.v
// Parameter decode, diagnostic record and emergency frame builder
// Operation
// - General fault sends code 7010, error register bits 0 and 7, zero info.
// - Any change in diagnostic bytes 0-3 sends code 7011 with module number.
// - Emergency identifier is 129 minus 1 plus node identifier.
// - Unused additional information bytes are sent as zero.
// - Error register bits: generic, current, voltage, temp, comm, profile, reserved, maker.
// - Track input setting 1 inverts the input, 0 passes it.
// - Diagnostic mask bit 1 suppresses that unit's diagnostics.
// - Measurement bit 0 selects frequency, 1 period duration.
// - Count direction 00 basic, 01 none, 10 up, 11 down.
// - Filter code 00 is 2 us, 01 is 16 us, others reserved.
// - Index-input mode decode; undefined codes are reserved.
// - Count mode decode; 0101 to 1110 reserved.
// - Status mode 00 gives compare window, 11 follows pulse output.
// - Pulse mode 0000 period/duty, 0001 high/low time, 1111 plain.
// - Aux output function resets to 3f, plain process-data output.
// - Aux read selectors reset to 20, 21, 40.
// - Aux write selectors reset to 60, 61, 70.
// - Four-byte diagnostic record, hardware and parameter faults at bits 7, 6.
// - Module-present shows 1 only when the module is plugged.
// - Class revision equals major times 1000 plus minor.
`default_nettype none
`include "cpwm_defs.vh"
module cpwm_param_diag (
	input wire clk_i,
	input wire rst_i,
	// Configuration write port
	input wire cfg_we_i,
	input wire [7:0] cfg_sel_i,
	input wire [7:0] cfg_data_i,
	// Counter inputs and state
	input wire [1:0] track_a_i,
	input wire [1:0] track_b_i,
	input wire [1:0] index_i,
	input wire [31:0] count_one_i,
	input wire [31:0] count_two_i,
	input wire [31:0] cmp_low_one_i,
	input wire [31:0] cmp_low_two_i,
	input wire [31:0] cmp_high_one_i,
	input wire [31:0] cmp_high_two_i,
	input wire [1:0] pulse_output_i,
	// Fault sources, presence and identity
	input wire hardware_fault_flag_i,
	input wire general_fault_i,
	input wire [1:0] pulse_out_diag_i,
	input wire [1:0] aux_out_diag_i,
	input wire slot_plugged_i,
	input wire base_only_i,
	input wire [6:0] node_id_i,
	input wire [7:0] module_num_i,
	input wire [7:0] rev_major_i,
	input wire [7:0] rev_minor_i,
	// Emergency frame handshake
	input wire emcy_ready_i,
	output wire emcy_valid_o,
	output reg [10:0] emcy_id_o,
	output reg [63:0] emcy_data_o,
	// Conditioned inputs
	output wire [1:0] track_a_o,
	output wire [1:0] track_b_o,
	output wire [1:0] index_o,
	// Decoded configuration
	output reg [1:0] period_mode_o,
	output reg [1:0] dir_up_o,
	output reg [1:0] dir_down_o,
	output reg [1:0] dir_none_o,
	output reg [1:0] quad_mode_o,
	output reg [1:0] cnt_plain_o,
	output reg [1:0] idx_plain_o,
	output reg [1:0] pwm_high_low_time_definition_o,
	output reg [1:0] pwm_plain_o,
	output reg [1:0] aux_plain_o,
	output reg [1:0] window_status_bit_o,
	output reg [47:0] aux_sel_o,
	// Diagnostics and identity
	output wire [31:0] diag_record_o,
	output reg module_present_o,
	output reg [15:0] class_rev_o
);
	// Configuration select codes
	localparam [7:0] S_INV_A1 = 8'h75;
	localparam [7:0] S_INV_B1 = 8'h76;
	localparam [7:0] S_INV_Z1 = 8'h77;
	localparam [7:0] S_MASK_C1 = 8'h78;
	localparam [7:0] S_MEAS1 = 8'h79;
	localparam [7:0] S_DIR1 = 8'h7a;
	localparam [7:0] S_FZ1 = 8'h7b;
	localparam [7:0] S_FAB1 = 8'h7c;
	localparam [7:0] S_IDX1 = 8'h7f;
	localparam [7:0] S_CMODE1 = 8'h80;
	localparam [7:0] S_INV_A2 = 8'h81;
	localparam [7:0] S_INV_B2 = 8'h82;
	localparam [7:0] S_INV_Z2 = 8'h83;
	localparam [7:0] S_MASK_C2 = 8'h84;
	localparam [7:0] S_MEAS2 = 8'h85;
	localparam [7:0] S_DIR2 = 8'h86;
	localparam [7:0] S_FZ2 = 8'h87;
	localparam [7:0] S_FAB2 = 8'h88;
	localparam [7:0] S_IDX2 = 8'h8b;
	localparam [7:0] S_CMODE2 = 8'h8c;
	localparam [7:0] S_MASK_P1 = 8'h8d;
	localparam [7:0] S_AUX1 = 8'h8e;
	localparam [7:0] S_STS1 = 8'h8f;
	localparam [7:0] S_PWM1 = 8'h92;
	localparam [7:0] S_MASK_P2 = 8'h93;
	localparam [7:0] S_AUX2 = 8'h94;
	localparam [7:0] S_STS2 = 8'h95;
	localparam [7:0] S_PWM2 = 8'h98;
	localparam [7:0] S_SEL_BASE = 8'h99;
	// Emitter states
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_SEND = 2'h1;

	reg [1:0] inv_a_r;
	reg [1:0] inv_b_r;
	reg [1:0] inv_z_r;
	reg [3:0] mask_r;
	reg [1:0] meas_r;
	reg [3:0] dir_r;
	reg [3:0] filt_z_r;
	reg [3:0] filt_ab_r;
	reg [7:0] idx_mode_r;
	reg [7:0] cnt_mode_r;
	reg [11:0] aux_mode_r;
	reg [3:0] sts_mode_r;
	reg [7:0] pwm_mode_r;
	reg [3:0] par_fault_r;
	reg [47:0] sel_r;
	reg [3:0] bad;
	reg [1:0] state_r;
	reg pend_gen_r;
	reg pend_chg_r;
	reg gen_prev_r;
	wire [3:0] changed;
	wire [31:0] diag;
	integer i;
	integer j;

	// Reserved-code checks, kept as functions so both channels' writes use the same check
	function idx_reserved;
		input [3:0] c;
		begin
			idx_reserved = (c == 4'h6) || ((c >= 4'ha) && (c <= 4'he));
		end
	endfunction
	function cmode_reserved;
		input [3:0] c;
		begin
			cmode_reserved = (c > `CNT_MODE_QUAD4) && (c != `CNT_MODE_PLAIN);
		end
	endfunction
	function pwm_reserved;
		input [3:0] c;
		begin
			pwm_reserved = (c != `PWM_PERIOD_DUTY_DEFINITION) && (c != `PWM_HIGH_LOW_TIME_DEFINITION) && (c != `PWM_PLAIN);
		end
	endfunction

	// Reserved code check on the incoming write
	always @* begin
		bad = 4'h0;
		if (cfg_we_i) begin
			case (cfg_sel_i)
				S_FZ1, S_FAB1: bad[0] = cfg_data_i[1];
				S_FZ2, S_FAB2: bad[1] = cfg_data_i[1];
				S_IDX1: bad[0] = idx_reserved(cfg_data_i[3:0]);
				S_IDX2: bad[1] = idx_reserved(cfg_data_i[3:0]);
				S_CMODE1: bad[0] = cmode_reserved(cfg_data_i[3:0]);
				S_CMODE2: bad[1] = cmode_reserved(cfg_data_i[3:0]);
				S_STS1: bad[2] = (cfg_data_i[1:0] == 2'h1) || (cfg_data_i[1:0] == 2'h2);
				S_STS2: bad[3] = (cfg_data_i[1:0] == 2'h1) || (cfg_data_i[1:0] == 2'h2);
				S_PWM1: bad[2] = pwm_reserved(cfg_data_i[3:0]);
				S_PWM2: bad[3] = pwm_reserved(cfg_data_i[3:0]);
				default: bad = 4'h0;
			endcase
		end
	end

	// Parameter store; reserved codes are stored too but flagged
	always @(posedge clk_i) begin
		if (rst_i) begin
			inv_a_r <= 2'h0;
			inv_b_r <= 2'h0;
			inv_z_r <= 2'h0;
			mask_r <= 4'h0;
			meas_r <= 2'h0;
			dir_r <= 4'h0;
			filt_z_r <= 4'h0;
			filt_ab_r <= 4'h0;
			idx_mode_r <= 8'h11;
			cnt_mode_r <= 8'h00;
			aux_mode_r <= {`AUX_MODE_RST, `AUX_MODE_RST};
			sts_mode_r <= 4'h0;
			pwm_mode_r <= 8'h00;
			par_fault_r <= 4'h0;
			sel_r <= {`AUX_WR3_RST, `AUX_WR2_RST, `AUX_WR1_RST,
				`AUX_RD3_RST, `AUX_RD2_RST, `AUX_RD1_RST};
		end else if (cfg_we_i) begin
			// A reserved code written to a filter, index, count-mode, status or pulse-mode field sets the fault flag of its unit
			for (i = 0; i < 4; i = i + 1) begin
				if (bad[i]) begin
					par_fault_r[i] <= 1'b1;
				end
			end
			case (cfg_sel_i)
				S_INV_A1: inv_a_r[0] <= cfg_data_i[0];
				S_INV_B1: inv_b_r[0] <= cfg_data_i[0];
				S_INV_Z1: inv_z_r[0] <= cfg_data_i[0];
				S_INV_A2: inv_a_r[1] <= cfg_data_i[0];
				S_INV_B2: inv_b_r[1] <= cfg_data_i[0];
				S_INV_Z2: inv_z_r[1] <= cfg_data_i[0];
				S_MASK_C1: mask_r[0] <= cfg_data_i[0];
				S_MASK_C2: mask_r[1] <= cfg_data_i[0];
				S_MASK_P1: mask_r[2] <= cfg_data_i[0];
				S_MASK_P2: mask_r[3] <= cfg_data_i[0];
				S_MEAS1: meas_r[0] <= cfg_data_i[0];
				S_MEAS2: meas_r[1] <= cfg_data_i[0];
				S_DIR1: dir_r[1:0] <= cfg_data_i[1:0];
				S_DIR2: dir_r[3:2] <= cfg_data_i[1:0];
				S_FZ1: filt_z_r[1:0] <= cfg_data_i[1:0];
				S_FZ2: filt_z_r[3:2] <= cfg_data_i[1:0];
				S_FAB1: filt_ab_r[1:0] <= cfg_data_i[1:0];
				S_FAB2: filt_ab_r[3:2] <= cfg_data_i[1:0];
				S_IDX1: idx_mode_r[3:0] <= cfg_data_i[3:0];
				S_IDX2: idx_mode_r[7:4] <= cfg_data_i[3:0];
				S_CMODE1: cnt_mode_r[3:0] <= cfg_data_i[3:0];
				S_CMODE2: cnt_mode_r[7:4] <= cfg_data_i[3:0];
				S_AUX1: aux_mode_r[5:0] <= cfg_data_i[5:0];
				S_AUX2: aux_mode_r[11:6] <= cfg_data_i[5:0];
				S_STS1: sts_mode_r[1:0] <= cfg_data_i[1:0];
				S_STS2: sts_mode_r[3:2] <= cfg_data_i[1:0];
				S_PWM1: pwm_mode_r[3:0] <= cfg_data_i[3:0];
				S_PWM2: pwm_mode_r[7:4] <= cfg_data_i[3:0];
				default: begin
					if ((cfg_sel_i >= S_SEL_BASE) && (cfg_sel_i < S_SEL_BASE + 8'h06)) begin
						sel_r[(cfg_sel_i - S_SEL_BASE) * 8 +: 8] <= cfg_data_i;
					end
				end
			endcase
			// Valid write to a filter, index, count-mode, status or pulse-mode field of the same unit releases the fault
			case (cfg_sel_i)
				S_FZ1, S_FAB1, S_IDX1, S_CMODE1: if (!bad[0]) par_fault_r[0] <= 1'b0;
				S_FZ2, S_FAB2, S_IDX2, S_CMODE2: if (!bad[1]) par_fault_r[1] <= 1'b0;
				S_STS1, S_PWM1: if (!bad[2]) par_fault_r[2] <= 1'b0;
				S_STS2, S_PWM2: if (!bad[3]) par_fault_r[3] <= 1'b0;
				default: par_fault_r <= par_fault_r | bad;
			endcase
		end
	end

	// Input conditioners, one per track and index input
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : ch
			cpwm_input_cond u_a (.clk_i(clk_i), .rst_i(rst_i), .raw_i(track_a_i[g]),
				.invert_i(inv_a_r[g]), .filter_i(filt_ab_r[2*g +: 2]), .clean_o(track_a_o[g]));
			cpwm_input_cond u_b (.clk_i(clk_i), .rst_i(rst_i), .raw_i(track_b_i[g]),
				.invert_i(inv_b_r[g]), .filter_i(filt_ab_r[2*g +: 2]), .clean_o(track_b_o[g]));
			cpwm_input_cond u_z (.clk_i(clk_i), .rst_i(rst_i), .raw_i(index_i[g]),
				.invert_i(inv_z_r[g]), .filter_i(filt_z_r[2*g +: 2]), .clean_o(index_o[g]));
			cpwm_diag_byte u_d (.clk_i(clk_i), .rst_i(rst_i), .mask_i(mask_r[g]),
				.hw_fault_i(hardware_fault_flag_i), .par_fault_i(par_fault_r[g]),
				.pulse_diag_i(1'b0), .aux_diag_i(1'b0),
				.diag_o(diag[8*g +: 8]), .changed_o(changed[g]));
			cpwm_diag_byte u_p (.clk_i(clk_i), .rst_i(rst_i), .mask_i(mask_r[g+2]),
				.hw_fault_i(hardware_fault_flag_i), .par_fault_i(par_fault_r[g+2]),
				.pulse_diag_i(pulse_out_diag_i[g]), .aux_diag_i(aux_out_diag_i[g]),
				.diag_o(diag[8*(g+2) +: 8]), .changed_o(changed[g+2]));
		end
	endgenerate
	assign diag_record_o = diag;

	// Registered decodes for the datapaths
	always @(posedge clk_i) begin
		if (rst_i) begin
			period_mode_o <= 2'h0;
			dir_up_o <= 2'h0;
			dir_down_o <= 2'h0;
			dir_none_o <= 2'h0;
			quad_mode_o <= 2'h0;
			cnt_plain_o <= 2'h0;
			idx_plain_o <= 2'h0;
			pwm_high_low_time_definition_o <= 2'h0;
			pwm_plain_o <= 2'h0;
			aux_plain_o <= 2'h3;
			window_status_bit_o <= 2'h0;
			aux_sel_o <= 48'h0;
			module_present_o <= 1'b0;
			class_rev_o <= 16'h0000;
		end else begin
			period_mode_o <= meas_r;
			for (j = 0; j < 2; j = j + 1) begin
				dir_up_o[j] <= (dir_r[2*j +: 2] == `DIR_UP);
				dir_down_o[j] <= (dir_r[2*j +: 2] == `DIR_DOWN);
				dir_none_o[j] <= (dir_r[2*j +: 2] == `DIR_NONE);
				quad_mode_o[j] <= (cnt_mode_r[4*j +: 4] >= 4'h2) && (cnt_mode_r[4*j +: 4] <= `CNT_MODE_QUAD4);
				cnt_plain_o[j] <= (cnt_mode_r[4*j +: 4] == `CNT_MODE_PLAIN);
				idx_plain_o[j] <= (idx_mode_r[4*j +: 4] == `IDX_PLAIN);
				pwm_high_low_time_definition_o[j] <= (pwm_mode_r[4*j +: 4] == `PWM_HIGH_LOW_TIME_DEFINITION);
				pwm_plain_o[j] <= (pwm_mode_r[4*j +: 4] == `PWM_PLAIN);
				aux_plain_o[j] <= (aux_mode_r[6*j +: 6] == `AUX_MODE_RST);
			end
			// Reserved status codes hold the bit low
			window_status_bit_o[0] <= (sts_mode_r[1:0] == `STS_PULSE) ? pulse_output_i[0] :
				(sts_mode_r[1:0] == `STS_WINDOW) && (count_one_i >= cmp_low_one_i) &&
				(count_one_i < cmp_high_one_i);
			window_status_bit_o[1] <= (sts_mode_r[3:2] == `STS_PULSE) ? pulse_output_i[1] :
				(sts_mode_r[3:2] == `STS_WINDOW) && (count_two_i >= cmp_low_two_i) &&
				(count_two_i < cmp_high_two_i);
			aux_sel_o <= sel_r;
			module_present_o <= slot_plugged_i & ~base_only_i;
			class_rev_o <= {8'h00, rev_major_i} * `REV_MULT + {8'h00, rev_minor_i};
		end
	end

	// Emergency emitter; general fault has priority over diagnostic change
	assign emcy_valid_o = (state_r == ST_SEND);
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			pend_gen_r <= 1'b0;
			pend_chg_r <= 1'b0;
			gen_prev_r <= 1'b0;
			emcy_id_o <= 11'h000;
			emcy_data_o <= 64'h0;
		end else begin
			gen_prev_r <= general_fault_i;
			// New events set pending even while a frame is being sent
			if (general_fault_i && !gen_prev_r) begin
				pend_gen_r <= 1'b1;
			end
			if (|changed) begin
				pend_chg_r <= 1'b1;
			end
			case (state_r)
				ST_IDLE: begin
					emcy_id_o <= `EMCY_BASE_ID - `EMCY_ID_OFFSET + {4'h0, node_id_i};
					if (pend_gen_r) begin
						pend_gen_r <= general_fault_i && !gen_prev_r;
						// Bytes: code low, code high, error register, five zero bytes
						emcy_data_o <= {40'h0, `EMCY_ERR_GENERAL, `EMCY_CODE_GENERAL};
						state_r <= ST_SEND;
					end else if (pend_chg_r) begin
						pend_chg_r <= |changed;
						emcy_data_o <= {40'h0, module_num_i, `EMCY_CODE_DIAG_CHG};
						state_r <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (emcy_ready_i) begin
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- cpwm_param_diag_props.sv
// Port-level checker for the parameter and diagnostic map
`default_nettype none
module cpwm_param_diag_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cfg_we_i,
	input wire logic [7:0] cfg_sel_i,
	input wire logic [7:0] cfg_data_i,
	input wire logic general_fault_i,
	input wire logic slot_plugged_i,
	input wire logic base_only_i,
	input wire logic [6:0] node_id_i,
	input wire logic [7:0] module_num_i,
	input wire logic [7:0] rev_major_i,
	input wire logic [7:0] rev_minor_i,
	input wire logic emcy_ready_i,
	input wire logic emcy_valid_o,
	input wire logic [10:0] emcy_id_o,
	input wire logic [63:0] emcy_data_o,
	input wire logic [1:0] period_mode_o,
	input wire logic [47:0] aux_sel_o,
	input wire logic module_present_o,
	input wire logic [15:0] class_rev_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Frame content and timing
	sel_reset_a: assert property ($fell(rst_i) |-> ##1 aux_sel_o == 48'h706160402120)
		else $error("aux selectors not at reset values");
	info_zero_a: assert property (emcy_valid_o |-> emcy_data_o[63:24] == 40'h0)
		else $error("unused frame bytes not zero");
	frame_id_a: assert property (emcy_valid_o |-> emcy_id_o == 11'h080 + {4'h0, node_id_i})
		else $error("frame identifier wrong");
	general_err_a: assert property (emcy_valid_o && emcy_data_o[15:0] == 16'h7010 |-> emcy_data_o[23:16] == 8'h81)
		else $error("general frame error byte wrong");
	diag_frame_a: assert property (emcy_valid_o && emcy_data_o[15:0] == 16'h7011 |-> emcy_data_o[23:16] == module_num_i)
		else $error("diag frame module byte wrong");
	// Held offer: a frame must not move under a stalled receiver
	frame_hold_a: assert property (emcy_valid_o && !emcy_ready_i |=> emcy_valid_o && $stable(emcy_data_o) && $stable(emcy_id_o))
		else $error("frame dropped before acceptance");
	fault_frame_a: assert property ($rose(general_fault_i) && !emcy_valid_o |-> ##[2:3] emcy_valid_o)
		else $error("no frame after general fault");
	present_on_a: assert property ((slot_plugged_i && !base_only_i) [*3] |-> module_present_o)
		else $error("module not shown present");
	present_off_a: assert property ((!slot_plugged_i || base_only_i) [*3] |-> !module_present_o)
		else $error("module shown present wrongly");
	class_rev_a: assert property (!rst_i [*3] |-> class_rev_o == {8'h00, rev_major_i} * 16'd1000 + {8'h00, rev_minor_i})
		else $error("class revision wrong");
	meas_mode_a: assert property (cfg_we_i && cfg_sel_i == 8'h79 |-> ##2 period_mode_o[0] == $past(cfg_data_i[0], 2))
		else $error("measurement mode not applied");
	// Main scenarios reached
	gen_cov: cover property (emcy_valid_o && emcy_ready_i && emcy_data_o[15:0] == 16'h7010);
	diag_cov: cover property (emcy_valid_o && emcy_ready_i && emcy_data_o[15:0] == 16'h7011);
	stall_cov: cover property (emcy_valid_o && !emcy_ready_i [*3]);
endmodule
`default_nettype wire

//--- emcy_sink.sv
// Gateway model that accepts emergency frames after a set stall
`default_nettype none
module emcy_sink (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic emcy_valid_i,
	input wire logic [63:0] emcy_data_i,
	input wire logic [3:0] wait_i,
	output logic emcy_ready_o,
	output logic [15:0] last_code_o,
	output logic [7:0] last_err_o,
	output int frames_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	// Ready only after the stall; a frame is taken at the edge with both high
	always @(posedge clk_i) begin
		if (rst_i) begin
			emcy_ready_o <= 1'b0;
			cnt <= 4'h0;
			frames_o <= 0;
		end else if (emcy_valid_i && emcy_ready_o) begin
			emcy_ready_o <= 1'b0;
			cnt <= 4'h0;
			frames_o <= frames_o + 1;
			last_code_o <= emcy_data_i[15:0];
			last_err_o <= emcy_data_i[23:16];
		end else if (emcy_valid_i) begin
			if (cnt >= wait_i)
				emcy_ready_o <= 1'b1;
			else
				cnt <= cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

//--- counter_pwm_param_diag_map_tb.sv
// Self-checking bench for the parameter and diagnostic map
`default_nettype none
module counter_pwm_param_diag_map_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0;
	logic rst_i = 1;
	logic cfg_we_i = 0;
	logic hardware_fault_flag_i = 0;
	logic general_fault_i = 0;
	logic slot_plugged_i = 1;
	logic base_only_i = 0;
	logic emcy_ready_i;
	logic emcy_valid_o;
	logic module_present_o;
	logic [7:0] cfg_sel_i = 0;
	logic [7:0] cfg_data_i = 0;
	logic [7:0] module_num_i = 8'h03;
	logic [7:0] rev_major_i = 8'h02;
	logic [7:0] rev_minor_i = 8'h07;
	logic [6:0] node_id_i = 7'h05;
	logic [1:0] track_a_i = 0;
	logic [1:0] track_b_i = 0;
	logic [1:0] index_i = 0;
	logic [1:0] pulse_output_i = 0;
	logic [1:0] pulse_out_diag_i = 0;
	logic [1:0] aux_out_diag_i = 0;
	logic [31:0] count_one_i = 0;
	logic [31:0] count_two_i = 0;
	logic [31:0] cmp_low_one_i = 10;
	logic [31:0] cmp_low_two_i = 0;
	logic [31:0] cmp_high_one_i = 20;
	logic [31:0] cmp_high_two_i = 0;
	logic [10:0] emcy_id_o;
	logic [63:0] emcy_data_o;
	logic [1:0] track_a_o, track_b_o, index_o, period_mode_o, dir_up_o, dir_down_o, dir_none_o;
	logic [1:0] quad_mode_o, cnt_plain_o, idx_plain_o, pwm_high_low_time_definition_o, pwm_plain_o, aux_plain_o;
	logic [1:0] window_status_bit_o;
	logic [47:0] aux_sel_o;
	logic [31:0] diag_record_o;
	logic [15:0] class_rev_o;
	logic [3:0] stall = 0;
	logic [15:0] last_code;
	logic [7:0] last_err;
	int frames, n_errors = 0, checks_done = 0, f, c, o;

	cpwm_param_diag cpwm_param_diag_inst (.clk_i, .rst_i, .cfg_we_i, .cfg_sel_i, .cfg_data_i,
		.track_a_i, .track_b_i, .index_i, .count_one_i, .count_two_i, .cmp_low_one_i, .cmp_low_two_i,
		.cmp_high_one_i, .cmp_high_two_i, .pulse_output_i, .hardware_fault_flag_i, .general_fault_i,
		.pulse_out_diag_i, .aux_out_diag_i, .slot_plugged_i, .base_only_i, .node_id_i, .module_num_i,
		.rev_major_i, .rev_minor_i, .emcy_ready_i, .emcy_valid_o, .emcy_id_o, .emcy_data_o, .track_a_o,
		.track_b_o, .index_o, .period_mode_o, .dir_up_o, .dir_down_o, .dir_none_o, .quad_mode_o,
		.cnt_plain_o, .idx_plain_o, .pwm_high_low_time_definition_o, .pwm_plain_o, .aux_plain_o, .window_status_bit_o,
		.aux_sel_o, .diag_record_o, .module_present_o, .class_rev_o);
	emcy_sink emcy_sink_inst (.clk_i, .rst_i, .emcy_valid_i(emcy_valid_o), .emcy_data_i(emcy_data_o),
		.wait_i(stall), .emcy_ready_o(emcy_ready_i), .last_code_o(last_code), .last_err_o(last_err),
		.frames_o(frames));

	// 20 MHz clock
	initial begin
		forever #25 clk_i = ~clk_i;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle write strobe, then wait out the two-edge decode latency
	task automatic wr(input logic [7:0] sel, input logic [7:0] data);
		@(negedge clk_i);
		cfg_we_i = 1;
		cfg_sel_i = sel;
		cfg_data_i = data;
		@(negedge clk_i);
		cfg_we_i = 0;
		cyc(2);
	endtask

	task results;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog sized well beyond the whole sequence
	initial begin
		#(20000 * 50);
		n_errors++;
		results;
	end

	initial begin
		cyc(2);
		rst_i = 0;
		cyc(3);
		chk(aux_sel_o, 48'h706160402120);
		chk(aux_plain_o, 2'h3);
		chk(diag_record_o, 0);
		chk(class_rev_o, 16'd2007);
		wr(8'h9e, 8'h5a);
		chk(aux_sel_o, 48'h5a6160402120);
		$display("test reset done");
		// Decodes for both counter channels; channel 2 fields sit 12 above
		for (c = 0; c < 2; c++) begin
			o = c * 12;
			for (f = 0; f < 4; f++) begin
				wr(8'h7a + o, f);
				chk({dir_down_o[c], dir_up_o[c], dir_none_o[c]}, f == 0 ? 0 : 1 << (f - 1));
			end
			wr(8'h79 + o, 1);
			chk(period_mode_o[c], 1);
			wr(8'h79 + o, 0);
			chk(period_mode_o[c], 0);
			wr(8'h80 + o, 8'h0f);
			chk(cnt_plain_o[c], 1);
			wr(8'h80 + o, 8'h04);
			chk({quad_mode_o[c], cnt_plain_o[c]}, 2'b10);
			wr(8'h80 + o, 8'h05);
			chk(diag_record_o[c * 8 + 6], 1);
			wr(8'h80 + o, 8'h00);
			chk(diag_record_o[c * 8 + 6], 0);
			wr(8'h7f + o, 8'h0f);
			chk(idx_plain_o[c], 1);
			wr(8'h7f + o, 8'h06);
			chk(diag_record_o[c * 8 + 6], 1);
			wr(8'h7f + o, 8'h01);
			chk({idx_plain_o[c], diag_record_o[c * 8 + 6]}, 0);
		end
		$display("test counter decode done");
		// Pulse channels: modes, reserved code, mask
		for (c = 0; c < 2; c++) begin
			o = c * 6;
			wr(8'h92 + o, 8'h01);
			chk(pwm_high_low_time_definition_o[c], 1);
			wr(8'h92 + o, 8'h0f);
			chk({pwm_plain_o[c], pwm_high_low_time_definition_o[c]}, 2'b10);
			wr(8'h92 + o, 8'h03);
			chk(diag_record_o[16 + c * 8 + 6], 1);
			wr(8'h92 + o, 8'h00);
			wr(8'h8d + o, 1);
			pulse_out_diag_i[c] = 1;
			aux_out_diag_i[c] = 1;
			cyc(4);
			chk(diag_record_o[16 + c * 8 +: 8], 0);
			wr(8'h8d + o, 0);
			chk(diag_record_o[16 + c * 8 +: 8], 8'h03);
		end
		cyc(40);
		chk(last_code, 16'h7011);
		chk(last_err, module_num_i);
		f = frames;
		hardware_fault_flag_i = 1;
		cyc(40);
		chk(diag_record_o, 32'h83838080);
		chk(frames, f + 1);
		$display("test pulse and diag done");
		// General fault with a slow gateway
		stall = 6;
		general_fault_i = 1;
		cyc(40);
		chk(last_code, 16'h7010);
		chk(last_err, 8'h81);
		$display("test general fault done");
		// Compare window then pulse follow
		wr(8'h8f, 0);
		for (f = 0; f < 4; f++) begin
			count_one_i = f[1] ? 19 + f[0] : 9 + f[0];
			cyc(4);
			chk(window_status_bit_o[0], f == 1 || f == 2);
		end
		wr(8'h8f, 3);
		wr(8'h95, 3);
		pulse_output_i = 2'b11;
		cyc(4);
		chk(window_status_bit_o, 2'b11);
		pulse_output_i = 2'b00;
		cyc(4);
		chk(window_status_bit_o, 2'b00);
		$display("test window done");
		// Inversion and the two filter lengths (40 and 320 cycles)
		wr(8'h75, 1);
		wr(8'h76, 1);
		wr(8'h77, 1);
		wr(8'h7c, 0);
		cyc(60);
		chk(track_a_o[0], 1);
		chk({index_o[0], track_b_o[0]}, 2'b11);
		track_a_i[0] = 1;
		cyc(30);
		chk(track_a_o[0], 1);
		cyc(20);
		chk(track_a_o[0], 0);
		wr(8'h7c, 1);
		track_a_i[0] = 0;
		cyc(300);
		chk(track_a_o[0], 0);
		cyc(40);
		chk(track_a_o[0], 1);
		$display("test inputs done");
		// Presence states
		slot_plugged_i = 0;
		cyc(4);
		chk(module_present_o, 0);
		slot_plugged_i = 1;
		base_only_i = 1;
		cyc(4);
		chk(module_present_o, 0);
		base_only_i = 0;
		cyc(4);
		chk(module_present_o, 1);
		$display("test presence done");
		results;
	end
endmodule

bind cpwm_param_diag cpwm_param_diag_props cpwm_param_diag_props_inst (.clk_i, .rst_i, .cfg_we_i,
	.cfg_sel_i, .cfg_data_i, .general_fault_i, .slot_plugged_i, .base_only_i, .node_id_i, .module_num_i,
	.rev_major_i, .rev_minor_i, .emcy_ready_i, .emcy_valid_o, .emcy_id_o, .emcy_data_o, .period_mode_o,
	.aux_sel_o, .module_present_o, .class_rev_o);
`default_nettype wire
